/* tb/seifc_tx_sink.sv */
// Transmitter-side partner model that takes characters from the block
`timescale 1ns/1ps
module seifc_tx_sink
(
	input  wire logic       sys_clk,
	input  wire logic       reset,
	input  wire logic       slow,
	input  wire logic       valid,
	input  wire logic [7:0] data,
	output logic            ready,
	output logic [7:0]      last_data
);
	// Slow mode stalls every other cycle to stretch the handshake
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			ready <= 1'b0;
			last_data <= 8'h00;
		end
		else
		begin
			ready <= slow ? ~ready : 1'b1;
			// Take the character only on a completed handshake
			if (valid && ready)
				last_data <= data;
		end
	end
endmodule // seifc_tx_sink

/* tb/testbench.sv */
// Self-checking testbench for the event identification and FIFO control block
`timescale 1ns/1ps
module testbench;
	import seifc_pkg::*;
	logic            sys_clk;
	logic            reset;
	logic            clk_en;
	logic            ir_sel;
	seifc_host_t     host;
	seifc_mode_t     mode;
	logic            ext_sel;
	logic            dma_tc;
	logic            char_tick;
	logic            rx_valid;
	seifc_rx_char_t  rx_char;
	logic            rx_ready;
	logic [3:0]      modem_pins;
	logic            tx_valid;
	logic [7:0]      tx_data;
	logic            tx_ready;
	logic [7:0]      sink_data;
	logic [7:0]      ev;
	logic [7:0]      rx_data;
	logic            rx_sr;
	logic            tx_sr;
	logic            fifos_on;
	logic [3:0]      deltas;
	int              fails;
	int              n_compared;

	seifc_core uut (.sys_clk(sys_clk), .reset(reset), .clk_en(clk_en), .host(host),
		.mode(mode), .extended_mode_select(ext_sel), .ir_status_select(ir_sel),
		.dma_legacy_used(1'b1), .dma_tc(dma_tc), .char_tick(char_tick),
		.rx_char_valid(rx_valid), .rx_char(rx_char), .rx_char_ready(rx_ready),
		.rx_overrun(1'b0), .tx_underrun(1'b0), .tx_shift_empty(1'b1),
		.modem_pins(modem_pins), .tx_accept(), .tx_char_valid_reg(tx_valid),
		.tx_char_data_reg(tx_data), .tx_char_ready(tx_ready), .event_ident_reg(ev),
		.rx_data_reg(rx_data), .rx_soft_reset_reg(rx_sr), .tx_soft_reset_reg(tx_sr),
		.fifos_on_ind(fifos_on), .modem_delta_reg(deltas));

	seifc_tx_sink sink (.sys_clk(sys_clk), .reset(reset), .slow(1'b1), .valid(tx_valid),
		.data(tx_data), .ready(tx_ready), .last_data(sink_data));

	// Free-running 10 MHz clock
	initial
	begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end

	// Inputs move 1 ns after the edge so nothing races the sampling
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			fails++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// One-cycle host strobe, then an idle cycle before the next one
	task automatic pulse();
		tick(1);
		host = '0;
		tick(1);
	endtask

	task automatic wr(input logic [7:0] d);
		host.shared_sel = 1'b1;
		host.wr = 1'b1;
		host.wdata = d;
		pulse();
	endtask

	// Receive push held until the FIFO shows room
	task automatic push(input logic [10:0] c);
		int i;
		rx_char = c;
		rx_valid = 1'b1;
		i = 0;
		while (rx_ready !== 1'b1 && i < 50)
		begin
			tick(1);
			i++;
		end
		tick(1);
		rx_valid = 1'b0;
		// Idle edge so back-to-back pushes never rewrite valid in one step
		tick(1);
		if (i == 50)
		begin
			fails++;
			complete_run();
		end
	endtask

	task automatic s_ctrl();
		host.shared_sel = 1'b1;
		host.rd = 1'b1;
		pulse();
		tick(1);
		chk(ev, 8'h01);
		wr(8'h01);
		tick(1);
		chk(ev, 8'hc1);
		chk({7'h0, fifos_on}, 8'h01);
	endtask

	// Line error outranks receive level; each clears by its own read
	task automatic s_line();
		push({3'h1, 8'ha5});
		tick(3);
		chk(ev, 8'hc6);
		host.lsr_rd = 1'b1;
		pulse();
		tick(1);
		chk(ev, 8'hc4);
		host.rxd_rd = 1'b1;
		pulse();
		chk(rx_data, 8'ha5);
		tick(1);
		chk(ev, 8'hc1);
	endtask

	// Fill to refusal at threshold 8, then drain in order
	task automatic s_fill();
		wr(8'h81);
		for (int k = 0; k < 8; k++)
			push({3'h0, 8'h10 + k[7:0]});
		tick(2);
		chk(ev, 8'hc4);
		chk({7'h0, rx_ready}, 8'h00);
		for (int k = 0; k < 8; k++)
		begin
			host.rxd_rd = 1'b1;
			pulse();
			chk(rx_data, 8'h10 + k[7:0]);
		end
		chk(ev, 8'hc1);
	endtask

	task automatic s_timeout();
		wr(8'h41);
		push({3'h0, 8'h3c});
		tick(2);
		chk(ev, 8'hc1);
		repeat (4)
		begin
			char_tick = 1'b1;
			tick(1);
			char_tick = 1'b0;
			tick(1);
		end
		tick(2);
		chk(ev, 8'hcc);
		host.rxd_rd = 1'b1;
		pulse();
		tick(1);
		chk(ev, 8'hc1);
	endtask

	task automatic s_modem();
		modem_pins = 4'h1;
		tick(8);
		chk({4'h0, deltas}, 8'h01);
		chk(ev, 8'hc0);
		host.msr_rd = 1'b1;
		pulse();
		tick(1);
		chk(ev, 8'hc1);
		// Infrared mode: status select hides the modem flag
		mode = SEIFC_MODE_SIR;
		ir_sel = 1'b1;
		modem_pins = 4'h0;
		tick(8);
		chk({4'h0, deltas}, 8'h01);
		chk(ev, 8'hc1);
		ir_sel = 1'b0;
		tick(2);
		chk(ev, 8'hc0);
		host.msr_rd = 1'b1;
		pulse();
		tick(1);
		chk(ev, 8'hc1);
		mode = SEIFC_MODE_UART;
		// Enable low freezes the synchronisers and flags
		clk_en = 1'b0;
		modem_pins = 4'h1;
		tick(8);
		chk({4'h0, deltas}, 8'h00);
		chk(ev, 8'hc1);
		clk_en = 1'b1;
		tick(8);
		chk({4'h0, deltas}, 8'h01);
		host.msr_rd = 1'b1;
		pulse();
		mode = SEIFC_MODE_CIR;
		wr(8'h00);
		tick(1);
		chk({7'h0, fifos_on}, 8'h01);
		mode = SEIFC_MODE_UART;
		wr(8'h01);
	endtask

	// Transmit to a stalling sink, then the per-source view
	task automatic s_ext();
		host.txd_data = 8'h5a;
		host.txd_wr = 1'b1;
		pulse();
		tick(10);
		chk(sink_data, 8'h5a);
		ext_sel = 1'b1;
		dma_tc = 1'b1;
		tick(1);
		dma_tc = 1'b0;
		tick(3);
		chk(ev, 8'h32);
		host.shared_sel = 1'b1;
		host.rd = 1'b1;
		pulse();
		tick(1);
		chk(ev, 8'h22);
	endtask

	// Pulses stand for the one cycle after the write edge; receive FIFO empties
	task automatic s_sreset();
		push({3'h0, 8'h77});
		tick(2);
		chk({7'h0, ev[0]}, 8'h01);
		host.shared_sel = 1'b1;
		host.wr = 1'b1;
		host.wdata = 8'h07;
		tick(1);
		host = '0;
		chk({6'h0, rx_sr, tx_sr}, 8'h03);
		tick(1);
		chk({6'h0, rx_sr, tx_sr}, 8'h00);
		chk({7'h0, ev[0]}, 8'h00);
	endtask

	// Hang guard
	initial
	begin
		repeat (5000) @(posedge sys_clk);
		fails++;
		complete_run();
	end

	initial
	begin
		fails = 0;
		n_compared = 0;
		reset = 1'b1;
		clk_en = 1'b1;
		ir_sel = 1'b0;
		host = '0;
		mode = SEIFC_MODE_UART;
		ext_sel = 1'b0;
		dma_tc = 1'b0;
		char_tick = 1'b0;
		rx_valid = 1'b0;
		rx_char = '0;
		modem_pins = 4'h0;
		tick(2);
		reset = 1'b0;
		chk(ev, 8'h01);
		tick(4);
		chk(ev, 8'h02);
		s_ctrl();
		s_line();
		s_fill();
		s_timeout();
		s_modem();
		s_ext();
		s_sreset();
		complete_run();
	end
endmodule // testbench

/* verilog/seifc_core.sv */
// Event identification and FIFO control for one serial/infrared channel
`timescale 1ns/1ps
module seifc_core
	import seifc_pkg::*;
(
	input  wire logic                 sys_clk,
	input  wire logic                 reset,
	input  wire logic                 clk_en,
	input  wire seifc_host_t          host,
	input  wire seifc_mode_t          mode,
	input  wire logic                 extended_mode_select,
	input  wire logic                 ir_status_select,
	input  wire logic                 dma_legacy_used,
	input  wire logic                 dma_tc,
	input  wire logic                 char_tick,
	input  wire logic                 rx_char_valid,
	input  wire seifc_rx_char_t       rx_char,
	output logic                      rx_char_ready,
	input  wire logic                 rx_overrun,
	input  wire logic                 tx_underrun,
	input  wire logic                 tx_shift_empty,
	input  wire logic [3:0]           modem_pins,
	output logic                      tx_accept,
	output logic                      tx_char_valid_reg,
	output logic [7:0]                tx_char_data_reg,
	input  wire logic                 tx_char_ready,
	output logic [7:0]                event_ident_reg,
	output logic [7:0]                rx_data_reg,
	output logic                      rx_soft_reset_reg,
	output logic                      tx_soft_reset_reg,
	output logic                      fifos_on_ind,
	output logic [3:0]                modem_delta_reg
);
	// Control register fields
	logic               fifo_en_reg;      // Written enable
	logic [1:0]         tx_threshold_sel; // Transmit threshold code
	logic [1:0]         rx_threshold_sel; // Receive threshold code
	// Event state
	logic               line_err_reg;     // Sticky line or halt event
	logic               head_seen_reg;    // Head error already reported
	logic               timeout_reg;      // Receive timeout pending
	logic [2:0]         idle_ticks_reg;   // Character times with no activity
	logic               tx_low_pend_reg;  // Legacy transmit-low latch
	logic               tx_cond_q_reg;    // Previous transmit-low condition
	logic               dma_count_event_reg;       // Terminal count seen
	logic               fifos_on_reg;     // Registered copy for the port
	// Modem pin synchronisers and filtered levels
	logic [3:0]         msync1_reg;
	logic [3:0]         msync2_reg;
	logic [3:0]         msync3_reg;
	logic [3:0]         mstable_reg;

	// FIFO side wires
	seifc_rx_char_t     rx_head;
	logic               rx_head_valid;
	logic [LEVEL_W-1:0] rx_level;
	logic [7:0]         tx_head;
	logic               tx_head_valid;
	logic [LEVEL_W-1:0] tx_level;

	// Shared address: read is identification, write is control
	wire ev_rd  = host.shared_sel & host.rd;
	wire fc_wr  = host.shared_sel & host.wr;
	wire is_cir = mode == SEIFC_MODE_CIR;
	// Remote-control mode overrides the written enable
	wire fifos_on = fifo_en_reg | is_cir;
	// Writing enable low flushes, except where it is ignored
	wire fc_clear = fc_wr & ~host.wdata[FC_FIFO_EN] & ~is_cir;
	wire rx_flush = fc_clear | (fc_wr & host.wdata[FC_RX_SR]);
	wire tx_flush = fc_clear | (fc_wr & host.wdata[FC_TX_SR]);
	wire rx_pop   = host.rxd_rd & rx_head_valid;
	wire rx_push  = rx_char_valid & rx_char_ready;
	wire tx_pop   = tx_head_valid & (~tx_char_valid_reg | tx_char_ready);

	// Threshold decode
	wire [LEVEL_W-1:0] tx_thr = seifc_thr(tx_threshold_sel, 1'b0);
	wire [LEVEL_W-1:0] rx_thr = seifc_thr(rx_threshold_sel, 1'b1);

	// Level conditions; disabled FIFOs act as one holding register
	wire rx_level_event = fifos_on ? (rx_level >= rx_thr) : (rx_level != '0);
	wire tx_level_event = fifos_on ? (tx_level < tx_thr) : (tx_level == '0);
	wire tx_empty_event = (tx_level == '0) & ~tx_char_valid_reg & tx_shift_empty;
	wire any_delta      = |modem_delta_reg;
	// Status select masks the modem flag in the infrared modes
	wire modem_event    = (mode == SEIFC_MODE_UART) ? any_delta
		: (any_delta & ~ir_status_select);
	// Errors count once the marked character is at the head
	wire head_err       = rx_head_valid & ~head_seen_reg
		& (rx_head.parity_fault | rx_head.framing_fault | rx_head.break_detect);
	wire line_set       = is_cir ? (rx_overrun | tx_underrun)
		: (rx_overrun | head_err);
	wire to_pend        = timeout_reg & fifos_on;

	// Modem sampling: a change counts once stages two and three agree
	wire [3:0] m_agree  = ~(msync2_reg ^ msync3_reg);
	wire [3:0] m_change = m_agree & (msync3_reg ^ mstable_reg);
	// Bit order cts, dsr, ri, dcd; ri counts only on its rise
	wire [3:0] m_delta_set = {m_change[3], m_change[2] & msync3_reg[2],
		m_change[1], m_change[0]};

	// Legacy priority encoder
	wire [3:0] legacy_code = line_err_reg ? CODE_LINE
		: rx_level_event ? CODE_RXLVL
		: to_pend ? CODE_RXTO
		: tx_low_pend_reg ? CODE_TXLOW
		: modem_event ? CODE_MODEM
		: CODE_NONE;
	wire [7:0] legacy_view = {fifos_on, fifos_on, 2'h0, legacy_code};
	// Extended view, one flag per source
	wire [7:0] ext_view;
	assign ext_view[7:6]          = 2'h0;
	assign ext_view[EXT_TX_EMPTY] = tx_empty_event;
	assign ext_view[EXT_DMA]      = dma_count_event_reg;
	assign ext_view[EXT_MODEM]    = modem_event;
	assign ext_view[EXT_LINE]     = line_err_reg;
	assign ext_view[EXT_TX_LVL]   = tx_level_event;
	assign ext_view[EXT_RX_LVL]   = rx_level_event | to_pend;
	// View picked every cycle
	wire [7:0] view_next = extended_mode_select ? ext_view : legacy_view;
	// Top-of-list transmit source acknowledged by the read
	wire tx_ack = ev_rd & ~extended_mode_select & (event_ident_reg[3:0] == CODE_TXLOW);
	wire tx_rise = tx_level_event & ~tx_cond_q_reg;

	// Receive buffer: holds error marks with each character
	seifc_fifo #(.WIDTH(RX_WORD_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
		.sys_clk   (sys_clk),
		.reset     (reset),
		.clk_en    (clk_en),
		.flush     (rx_flush),
		.limit_one (~fifos_on),
		.in_valid  (rx_char_valid),
		.in_data   (rx_char),
		.in_ready  (rx_char_ready),
		.out_valid (rx_head_valid),
		.out_data  (rx_head),
		.out_ready (host.rxd_rd),
		.level     (rx_level)
	);

	// Transmit buffer: host writes fill it, the output stage drains it
	seifc_fifo #(.WIDTH(TX_WORD_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
		.sys_clk   (sys_clk),
		.reset     (reset),
		.clk_en    (clk_en),
		.flush     (tx_flush),
		.limit_one (~fifos_on),
		.in_valid  (host.txd_wr),
		.in_data   (host.txd_data),
		.in_ready  (tx_accept),
		.out_valid (tx_head_valid),
		.out_data  (tx_head),
		.out_ready (~tx_char_valid_reg | tx_char_ready),
		.level     (tx_level)
	);

	// Control register; the soft reset bits are one-cycle pulses
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			fifo_en_reg       <= FC_RESET[FC_FIFO_EN];
			tx_threshold_sel  <= FC_RESET[FC_TX_THR +: 2];
			rx_threshold_sel  <= FC_RESET[FC_RX_THR +: 2];
			rx_soft_reset_reg <= 1'b0;
			tx_soft_reset_reg <= 1'b0;
			fifos_on_reg      <= 1'b0;
		end
		else if (clk_en)
		begin
			// Write only; reads at this address see identification
			if (fc_wr)
			begin
				fifo_en_reg      <= host.wdata[FC_FIFO_EN];
				tx_threshold_sel <= host.wdata[FC_TX_THR +: 2];
				rx_threshold_sel <= host.wdata[FC_RX_THR +: 2];
			end
			rx_soft_reset_reg <= fc_wr & host.wdata[FC_RX_SR];
			tx_soft_reset_reg <= fc_wr & host.wdata[FC_TX_SR];
			fifos_on_reg      <= fifos_on;
		end
	end
	assign fifos_on_ind = fifos_on_reg;

	// Identification register refreshed every enabled cycle; receive data loaded on a pop
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			event_ident_reg <= EV_RESET;
			rx_data_reg     <= 8'h00;
		end
		else if (clk_en)
		begin
			event_ident_reg <= view_next;
			if (rx_pop)
				rx_data_reg <= rx_head.data;
		end
	end

	// Line event: set wins over the status read
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			line_err_reg  <= 1'b0;
			head_seen_reg <= 1'b0;
		end
		else if (clk_en)
		begin
			line_err_reg  <= line_set | (line_err_reg & ~host.lsr_rd);
			// A new head needs fresh reporting
			head_seen_reg <= (rx_pop | rx_flush) ? 1'b0 : (head_seen_reg | head_err);
		end
	end

	// Receive timeout; any push or pop restarts the count
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			idle_ticks_reg <= 3'h0;
			timeout_reg    <= 1'b0;
		end
		else if (clk_en)
		begin
			if (rx_push || rx_pop || rx_flush || !rx_head_valid)
				idle_ticks_reg <= 3'h0;
			else if (char_tick && idle_ticks_reg != TIMEOUT_CHARS)
				idle_ticks_reg <= 3'(idle_ticks_reg + 3'h1);
			// Set on the fourth idle tick, clear on a data read
			// A flush in the same cycle empties the FIFO, so it must not set
			if (rx_head_valid && char_tick && !rx_push && !rx_pop && !rx_flush
				&& idle_ticks_reg == 3'(TIMEOUT_CHARS - 3'h1))
				timeout_reg <= 1'b1;
			else if (rx_pop || rx_flush)
				timeout_reg <= 1'b0;
		end
	end

	// Transmit-low latch for the legacy view and DMA flag
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			tx_low_pend_reg <= 1'b0;
			tx_cond_q_reg   <= 1'b0;
			dma_count_event_reg      <= 1'b0;
		end
		else if (clk_en)
		begin
			tx_cond_q_reg   <= tx_level_event;
			// New rise beats a same-cycle acknowledge
			tx_low_pend_reg <= tx_rise | (tx_low_pend_reg & ~tx_ack & ~host.txd_wr);
			dma_count_event_reg      <= (dma_tc & dma_legacy_used)
				| (dma_count_event_reg & ~(ev_rd & extended_mode_select));
		end
	end

	// Modem pins cross in through three flops before edge detection
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			msync1_reg      <= 4'h0;
			msync2_reg      <= 4'h0;
			msync3_reg      <= 4'h0;
			mstable_reg     <= 4'h0;
			modem_delta_reg <= 4'h0;
		end
		else if (clk_en)
		begin
			msync1_reg      <= modem_pins;
			msync2_reg      <= msync1_reg;
			msync3_reg      <= msync2_reg;
			mstable_reg     <= (m_agree & msync3_reg) | (~m_agree & mstable_reg);
			modem_delta_reg <= m_delta_set | (modem_delta_reg & {4{~host.msr_rd}});
		end
	end

	// Output stage toward the transmitter
	always_ff @(posedge sys_clk)
	begin
		if (reset || (clk_en && tx_flush))
		begin
			tx_char_valid_reg <= 1'b0;
			tx_char_data_reg  <= 8'h00;
		end
		else if (clk_en && (!tx_char_valid_reg || tx_char_ready))
		begin
			tx_char_valid_reg <= tx_pop;
			tx_char_data_reg  <= tx_head;
		end
	end

	// Checks; frozen cycles are excluded since all state holds
	property p_idle_code;
		@(posedge sys_clk) disable iff (reset || !clk_en)
		(!extended_mode_select && !line_err_reg && !rx_level_event && !to_pend
			&& !tx_low_pend_reg && !modem_event) |=> event_ident_reg[3:0] == 4'h1;
	endproperty
	a_idle_code: assert property (p_idle_code) else $error("idle code wrong");

	property p_line_top;
		@(posedge sys_clk) disable iff (reset || !clk_en)
		(!extended_mode_select && line_err_reg) |=> event_ident_reg[3:0] == 4'h6;
	endproperty
	a_line_top: assert property (p_line_top) else $error("line code not on top");

	property p_timeout_clear;
		@(posedge sys_clk) disable iff (reset || !clk_en)
		rx_pop |=> !timeout_reg;
	endproperty
	a_timeout_clear: assert property (p_timeout_clear) else $error("timeout kept");

	property p_txd_clears;
		@(posedge sys_clk) disable iff (reset || !clk_en)
		(host.txd_wr && !tx_rise) |=> !tx_low_pend_reg;
	endproperty
	a_txd_clears: assert property (p_txd_clears) else $error("tx low not cleared");

	property p_legacy_top;
		@(posedge sys_clk) disable iff (reset || !clk_en)
		!extended_mode_select |=> event_ident_reg[7:4] == {$past(fifos_on), $past(fifos_on), 2'h0};
	endproperty
	a_legacy_top: assert property (p_legacy_top) else $error("legacy high bits");

	property p_dma_set;
		@(posedge sys_clk) disable iff (reset || !clk_en)
		(dma_tc && dma_legacy_used) |=> dma_count_event_reg ##1 event_ident_reg[4] == $past(extended_mode_select);
	endproperty
	a_dma_set: assert property (p_dma_set) else $error("dma flag missed");

	property p_ext_top;
		@(posedge sys_clk) disable iff (reset || !clk_en)
		extended_mode_select |=> event_ident_reg[7:5] == {2'h0, $past(tx_empty_event)};
	endproperty
	a_ext_top: assert property (p_ext_top) else $error("extended high bits");

	property p_rx_soft;
		@(posedge sys_clk) disable iff (reset || !clk_en)
		(fc_wr && host.wdata[1]) |=> (rx_soft_reset_reg && rx_level == '0);
	endproperty
	a_rx_soft: assert property (p_rx_soft) else $error("rx soft reset failed");

	c_timeout_code: cover property (@(posedge sys_clk) event_ident_reg[3:0] == 4'hc);
	c_dma_flag: cover property (@(posedge sys_clk) extended_mode_select && event_ident_reg[4]);
	c_tx_full: cover property (@(posedge sys_clk) fifos_on && !tx_accept);
	c_cir_halt: cover property (@(posedge sys_clk) is_cir && tx_underrun);
endmodule // seifc_core

/* verilog/seifc_fifo.sv */
// Synchronous FIFO with valid/ready on both sides and a one-entry mode
`timescale 1ns/1ps
module seifc_fifo
	import seifc_pkg::*;
#(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
)
(
	input  wire logic                 sys_clk,
	input  wire logic                 reset,
	input  wire logic                 clk_en,
	input  wire logic                 flush,
	input  wire logic                 limit_one,
	input  wire logic                 in_valid,
	input  wire logic [WIDTH-1:0]     in_data,
	output logic                      in_ready,
	output logic                      out_valid,
	output logic [WIDTH-1:0]          out_data,
	input  wire logic                 out_ready,
	output logic [LEVEL_W-1:0]        level
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0]   mem [DEPTH];  // Storage, no reset needed
	logic [AW-1:0]      wr_ptr_reg;   // Next slot to fill
	logic [AW-1:0]      rd_ptr_reg;   // Oldest word
	logic [LEVEL_W-1:0] level_reg;    // Words held
	logic [LEVEL_W-1:0] level_next;
	logic               in_ready_reg; // Registered so the port comes from a flop
	logic               out_valid_reg;

	wire                push = in_valid & in_ready_reg;
	wire                pop  = out_ready & out_valid_reg;
	// Holding-register mode shrinks capacity to one word
	wire [LEVEL_W-1:0]  cap  = limit_one ? LEVEL_W'(1) : LEVEL_W'(DEPTH);

	assign level_next = flush ? '0 : LEVEL_W'(level_reg + LEVEL_W'(push) - LEVEL_W'(pop));
	assign in_ready   = in_ready_reg;
	assign out_valid  = out_valid_reg;
	assign out_data   = mem[rd_ptr_reg];
	assign level      = level_reg;

	// Pointers and flags; flush drops anything pushed in the same cycle
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			wr_ptr_reg    <= '0;
			rd_ptr_reg    <= '0;
			level_reg     <= '0;
			in_ready_reg  <= 1'b0;
			out_valid_reg <= 1'b0;
		end
		else if (clk_en)
		begin
			wr_ptr_reg    <= flush ? '0 : AW'(wr_ptr_reg + AW'(push));
			rd_ptr_reg    <= flush ? '0 : AW'(rd_ptr_reg + AW'(pop));
			level_reg     <= level_next;
			in_ready_reg  <= level_next < cap;
			out_valid_reg <= level_next != '0;
		end
	end

	// Data store
	always_ff @(posedge sys_clk)
	begin
		if (clk_en && push && !flush)
			mem[wr_ptr_reg] <= in_data;
	end
endmodule // seifc_fifo

/* verilog/seifc_pkg.sv */
// Constants, types and helpers shared by the serial event and FIFO control block
// Notes on behaviour
// - Legacy bit0 low means something pending
// - Code 0110 line error, cleared reading status
// - Code 0100 receive level, cleared by reading
// - Code 1100 receive timeout after four idle characters
// - Code 0010 transmit low, cleared read or write
// - Code 0000 modem change, cleared reading status
// - Timeout bit only when FIFOs on, top
// - Legacy bits 7:6 show FIFO enable, 5:4 zero
// - Extended view gives one flag per source
// - DMA flag set on count, read clears
// - Other extended flags clear on source acknowledge
// - Extended bit0 receive level or timeout
// - Extended bit1 transmit below threshold or empty
// - Bit2 line errors, reported at FIFO bottom
// - Remote-control mode bit2 overrun or underrun
// - Bit3 modem flag, gated by status select in the infrared modes
// - Bit5 mirrors transmitter fully empty, 7:6 zero
// - Control bit0 enables FIFOs, zero clears them
// - Remote-control mode keeps FIFOs always enabled
// - Control bit1 pulses receiver soft reset
// - Control bit2 pulses transmitter soft reset
// - Control bits 5:4 pick transmit threshold
// - Control bits 7:6 pick receive threshold
// - Reads give events, writes go to control
package seifc_pkg;
	// Buffer shape
	localparam int FIFO_DEPTH  = 8;
	localparam int LEVEL_W     = 4;
	localparam int RX_WORD_W   = 11;
	localparam int TX_WORD_W   = 8;
	// Legacy codes for the low nibble
	localparam logic [3:0] CODE_NONE  = 4'h1;
	localparam logic [3:0] CODE_LINE  = 4'h6;
	localparam logic [3:0] CODE_RXLVL = 4'h4;
	localparam logic [3:0] CODE_RXTO  = 4'hc;
	localparam logic [3:0] CODE_TXLOW = 4'h2;
	localparam logic [3:0] CODE_MODEM = 4'h0;
	// Extended flag positions
	localparam int EXT_RX_LVL   = 0;
	localparam int EXT_TX_LVL   = 1;
	localparam int EXT_LINE     = 2;
	localparam int EXT_MODEM    = 3;
	localparam int EXT_DMA      = 4;
	localparam int EXT_TX_EMPTY = 5;
	// Control field positions
	localparam int FC_FIFO_EN   = 0;
	localparam int FC_RX_SR     = 1;
	localparam int FC_TX_SR     = 2;
	localparam int FC_TX_THR    = 4;
	localparam int FC_RX_THR    = 6;
	// Reset values
	localparam logic [7:0] FC_RESET = 8'h00;
	localparam logic [7:0] EV_RESET = 8'h01;
	// Idle character times before a receive timeout
	localparam logic [2:0] TIMEOUT_CHARS = 3'h4;
	// Threshold tables
	localparam logic [LEVEL_W-1:0] TX_THR_0 = 4'h1;
	localparam logic [LEVEL_W-1:0] TX_THR_1 = 4'h3;
	localparam logic [LEVEL_W-1:0] TX_THR_2 = 4'h9;
	localparam logic [LEVEL_W-1:0] TX_THR_3 = 4'hd;
	localparam logic [LEVEL_W-1:0] RX_THR_0 = 4'h1;
	localparam logic [LEVEL_W-1:0] RX_THR_1 = 4'h4;
	localparam logic [LEVEL_W-1:0] RX_THR_2 = 4'h8;
	localparam logic [LEVEL_W-1:0] RX_THR_3 = 4'he;

	// Operating mode of the channel
	typedef enum logic [1:0] {
		SEIFC_MODE_UART  = 2'h0,
		SEIFC_MODE_SIR   = 2'h1,
		SEIFC_MODE_SHARP = 2'h2,
		SEIFC_MODE_CIR   = 2'h3
	} seifc_mode_t;

	// Received character with its error marks
	typedef struct packed {
		logic       break_detect;
		logic       framing_fault;
		logic       parity_fault;
		logic [7:0] data;
	} seifc_rx_char_t;

	// Host accesses, one-cycle strobes
	typedef struct packed {
		logic       shared_sel;
		logic       rd;
		logic       wr;
		logic [7:0] wdata;
		logic       rxd_rd;
		logic       txd_wr;
		logic [7:0] txd_data;
		logic       lsr_rd;
		logic       msr_rd;
	} seifc_host_t;

	// Decode a two-bit threshold select through a four-entry table
	function automatic logic [LEVEL_W-1:0] seifc_thr(input logic [1:0] sel,
		input logic is_rx);
		logic [LEVEL_W-1:0] t;
		t = '0;
		case (sel)
			2'h0: t = is_rx ? RX_THR_0 : TX_THR_0;
			2'h1: t = is_rx ? RX_THR_1 : TX_THR_1;
			2'h2: t = is_rx ? RX_THR_2 : TX_THR_2;
			default: t = is_rx ? RX_THR_3 : TX_THR_3;
		endcase
		return t;
	endfunction
endpackage
